// file: hw/cnc_pkg.sv
// Purpose: constants and types of the node configuration and indicator block
// Assumes: 250 MHz clock, synchronous active-high reset
// Notes: register offsets are word indices on the plain register port
package cnc_pkg;
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned PHASE_MS = 200;
   localparam int unsigned PHASE_CYC = PHASE_MS * 1000 * CLK_MHZ;
   localparam int unsigned PERIOD_PHASES = 5;
   localparam logic [2:0] ADDR_CTRL = 3'h0;
   localparam logic [2:0] ADDR_STATUS = 3'h1;
   localparam logic [2:0] ADDR_IRQ_STAT = 3'h2;
   localparam logic [2:0] ADDR_IRQ_MASK = 3'h3;
   localparam logic [2:0] ADDR_INPUTS = 3'h4;
   localparam logic [2:0] ADDR_POLARITY = 3'h5;
   localparam logic [2:0] ADDR_PAIR = 3'h6;
   localparam logic [3:0] IRQ_BITS = 4'h4;
   localparam logic [6:0] NODE_MAX = 7'h63;
   localparam logic [3:0] RATE_PAIR_BIT = 4'h8;

   typedef enum logic [1:0] {
      CNC_NMT_INIT = 2'b00,
      CNC_NMT_PREOP = 2'b01,
      CNC_NMT_OPER = 2'b10,
      CNC_NMT_STOP = 2'b11
   } cnc_nmt_e;

   typedef enum logic [1:0] {
      CNC_LED_OFF = 2'b00,
      CNC_LED_SINGLE = 2'b01,
      CNC_LED_DOUBLE = 2'b10,
      CNC_LED_BLINK = 2'b11
   } cnc_pat_e;

   typedef struct packed {
      logic [6:0] node_id;
      logic node_valid;
      logic fw_update;
      logic pair_mode;
      logic [2:0] rate_code;
      logic [9:0] rate_kbps;
   } cnc_cfg_s;

   typedef struct packed {
      logic fault_err;
      logic guard_fail;
      logic bus_off;
   } cnc_err_s;
endpackage

// file: hw/cnc_switch_decode.sv
// Purpose: decode the rotary switches into node configuration
// Assumes: switch levels steady and synchronous to the clock
// Notes: output registered, one cycle behind the switches
`timescale 1ns/10ps
module cnc_switch_decode (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic [3:0] i_sw_tens,
   input wire logic [3:0] i_sw_units,
   input wire logic [3:0] i_sw_rate,
   output cnc_pkg::cnc_cfg_s o_cfg
);
   cnc_pkg::cnc_cfg_s cfg_reg;
   cnc_pkg::cnc_cfg_s cfg_next;
   logic [6:0] id;

   always_comb begin
      // digits above nine are clamped so the id never exceeds 99
      id = 7'((i_sw_tens > 4'h9 ? 4'h9 : i_sw_tens) * 4'ha) + 7'(i_sw_units > 4'h9 ? 4'h9 : i_sw_units);
      cfg_next = cfg_reg;
      cfg_next.node_id = id;
      cfg_next.fw_update = (id == 7'h00);
      cfg_next.node_valid = (id != 7'h00) && (id <= cnc_pkg::NODE_MAX);
      cfg_next.pair_mode = (i_sw_rate >= cnc_pkg::RATE_PAIR_BIT);
      cfg_next.rate_code = i_sw_rate[2:0];
      case (i_sw_rate[2:0])
         3'h0: cfg_next.rate_kbps = 10'h00a;
         3'h1: cfg_next.rate_kbps = 10'h014;
         3'h2: cfg_next.rate_kbps = 10'h032;
         3'h3: cfg_next.rate_kbps = 10'h07d;
         3'h4: cfg_next.rate_kbps = 10'h0fa;
         3'h5: cfg_next.rate_kbps = 10'h1f4;
         3'h6: cfg_next.rate_kbps = 10'h320;
         default: cfg_next.rate_kbps = 10'h3e8;
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         cfg_reg <= '0;
      end else begin
         cfg_reg <= cfg_next;
      end
   end

   assign o_cfg = cfg_reg;
endmodule

// file: hw/cnc_led_pattern.sv
// Purpose: flash pattern generator shared by run and error indicators
// Assumes: i_phase_tick pulses once per 200 ms phase
// Notes: ten phase slots make two 1 s periods for single and double flash
`timescale 1ns/10ps
module cnc_led_pattern (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_phase_tick,
   input wire logic [3:0] i_slot,
   input cnc_pkg::cnc_pat_e i_pat,
   input wire logic i_solid,
   output logic o_led
);
   logic led_reg;
   logic led_next;

   always_comb begin
      led_next = 1'b0;
      if (i_solid) begin
         led_next = 1'b1;
      end else begin
         case (i_pat)
            cnc_pkg::CNC_LED_OFF: led_next = 1'b0;
            cnc_pkg::CNC_LED_BLINK: led_next = ~i_slot[0];
            cnc_pkg::CNC_LED_SINGLE: led_next = (i_slot == 4'h0);
            cnc_pkg::CNC_LED_DOUBLE: led_next = (i_slot == 4'h0) || (i_slot == 4'h2);
            default: led_next = 1'b0;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         led_reg <= 1'b0;
      end else begin
         led_reg <= led_next;
      end
   end

   assign o_led = led_reg;
endmodule

// file: hw/cnc_node.sv
// Purpose: top of the node configuration, state and indicator logic
// Assumes: nmt commands and error events arrive as one-cycle pulses from the protocol core
// Notes: registers on a plain port, read data one cycle after the read strobe
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module cnc_node #(
   parameter int unsigned CHANNELS = 16,
   parameter int unsigned PHASE_CYCLES = cnc_pkg::PHASE_CYC
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic [3:0] i_sw_tens,
   input wire logic [3:0] i_sw_units,
   input wire logic [3:0] i_sw_rate,
   input wire logic [CHANNELS-1:0] i_sensed_input_channel,
   input wire logic i_term_enable,
   input wire logic i_nmt_start,
   input wire logic i_nmt_stop,
   input wire logic i_nmt_preop,
   input wire logic i_nmt_reset,
   input wire logic i_ev_can_error,
   input wire logic i_ev_guard_fail,
   input wire logic i_bus_off,
   input wire logic [2:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic o_irq,
   output logic [6:0] o_node_id,
   output logic [9:0] o_rate_kbps,
   output logic o_pair_mode,
   output logic o_fw_update,
   output logic [6:0] o_pair_partner_id,
   output logic [CHANNELS-1:0] o_pair_out,
   output logic [CHANNELS-1:0] o_input_value,
   output logic [1:0] o_nmt_state,
   output logic o_run_led,
   output logic o_err_led,
   output logic o_term_led,
   output logic o_supply_indicator,
   output logic [CHANNELS-1:0] o_input_led
);
   cnc_pkg::cnc_cfg_s cfg;
   cnc_pkg::cnc_nmt_e nmt_reg;
   cnc_pkg::cnc_nmt_e nmt_next;
   cnc_pkg::cnc_err_s err_reg;
   cnc_pkg::cnc_err_s err_next;
   cnc_pkg::cnc_pat_e run_pat;
   cnc_pkg::cnc_pat_e err_pat;
   logic [31:0] phase_cnt_reg;
   logic [31:0] phase_cnt_next;
   logic [3:0] slot_reg;
   logic [3:0] slot_next;
   logic tick;
   logic [CHANNELS-1:0] pol_reg;
   logic [CHANNELS-1:0] pol_next;
   logic [CHANNELS-1:0] in_reg;
   logic [CHANNELS-1:0] in_next;
   logic [CHANNELS-1:0] pair_reg;
   logic [CHANNELS-1:0] pair_next;
   logic [6:0] partner_reg;
   logic [6:0] partner_next;
   // interrupt bits: 0 state change, 1 bus error, 2 guard fail, 3 bus off onset
   logic [3:0] ist_reg;
   logic [3:0] ist_next;
   logic [3:0] imask_reg;
   logic [3:0] imask_next;
   logic [3:0] ev;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic err_clr_reg;
   logic err_clr_next;

   ////////////////////////////////////////////////////////////////////////////
   cnc_switch_decode u_dec (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_sw_tens(i_sw_tens),
      .i_sw_units(i_sw_units),
      .i_sw_rate(i_sw_rate),
      .o_cfg(cfg)
   );

   ////////////////////////////////////////////////////////////////////////////
   // nmt state; firmware update mode holds the node in init
   // a reset command sends the node back through init, so pair mode restarts by itself
   always_comb begin
      nmt_next = nmt_reg;
      if (cfg.fw_update || !cfg.node_valid || i_nmt_reset) begin
         nmt_next = cnc_pkg::CNC_NMT_INIT;
      end else begin
         case (nmt_reg)
            cnc_pkg::CNC_NMT_INIT: begin
               nmt_next = cfg.pair_mode ? cnc_pkg::CNC_NMT_OPER : cnc_pkg::CNC_NMT_PREOP;
            end
            cnc_pkg::CNC_NMT_PREOP,
            cnc_pkg::CNC_NMT_OPER,
            cnc_pkg::CNC_NMT_STOP: begin
               if (i_nmt_start) begin
                  nmt_next = cnc_pkg::CNC_NMT_OPER;
               end else if (i_nmt_stop) begin
                  nmt_next = cnc_pkg::CNC_NMT_STOP;
               end else if (i_nmt_preop) begin
                  nmt_next = cnc_pkg::CNC_NMT_PREOP;
               end else if (cfg.pair_mode && nmt_reg == cnc_pkg::CNC_NMT_PREOP) begin
                  nmt_next = cnc_pkg::CNC_NMT_OPER;
               end
            end
            default: nmt_next = cnc_pkg::CNC_NMT_INIT;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         nmt_reg <= cnc_pkg::CNC_NMT_INIT;
      end else begin
         nmt_reg <= nmt_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // error indication; sticky flags clear on control write, new events win
   always_comb begin
      err_next = err_reg;
      if (err_clr_reg) begin
         err_next.fault_err = 1'b0;
         err_next.guard_fail = 1'b0;
      end
      if (i_ev_can_error) begin
         err_next.fault_err = 1'b1;
      end
      if (i_ev_guard_fail) begin
         err_next.guard_fail = 1'b1;
      end
      err_next.bus_off = i_bus_off;
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         err_reg <= '0;
      end else begin
         err_reg <= err_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // phase timer: ten 200 ms slots, two 1 s periods
   // one shared timer keeps the run and error flashes in step
   always_comb begin
      tick = (phase_cnt_reg == 32'(PHASE_CYCLES - 1));
      phase_cnt_next = tick ? 32'h0 : phase_cnt_reg + 32'h1;
      slot_next = slot_reg;
      if (tick) begin
         slot_next = (slot_reg == 4'(2 * cnc_pkg::PERIOD_PHASES - 1)) ? 4'h0 : slot_reg + 4'h1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         phase_cnt_reg <= 32'h0;
         slot_reg <= 4'h0;
      end else begin
         phase_cnt_reg <= phase_cnt_next;
         slot_reg <= slot_next;
      end
   end

   always_comb begin
      case (nmt_reg)
         cnc_pkg::CNC_NMT_STOP: run_pat = cnc_pkg::CNC_LED_SINGLE;
         cnc_pkg::CNC_NMT_PREOP: run_pat = cnc_pkg::CNC_LED_BLINK;
         default: run_pat = cnc_pkg::CNC_LED_OFF;
      endcase
      // guarding failure outranks a plain error
      if (err_reg.guard_fail) begin
         err_pat = cnc_pkg::CNC_LED_DOUBLE;
      end else if (err_reg.fault_err) begin
         err_pat = cnc_pkg::CNC_LED_SINGLE;
      end else begin
         err_pat = cnc_pkg::CNC_LED_OFF;
      end
   end

   cnc_led_pattern u_run (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_phase_tick(tick),
      .i_slot(slot_reg),
      .i_pat(run_pat),
      .i_solid(nmt_reg == cnc_pkg::CNC_NMT_OPER),
      .o_led(o_run_led)
   );

   cnc_led_pattern u_err (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_phase_tick(tick),
      .i_slot(slot_reg),
      .i_pat(err_pat),
      .i_solid(err_reg.bus_off),
      .o_led(o_err_led)
   );

   ////////////////////////////////////////////////////////////////////////////
   // inputs, polarity and pair outputs
   always_comb begin
      in_next = i_sensed_input_channel;
      partner_next = 7'h00;
      if (cfg.node_valid) begin
         // odd id pairs upward, even id pairs downward
         // id 99 has no upper mate, so it reports none
         partner_next = cfg.node_id[0] ? ((cfg.node_id == cnc_pkg::NODE_MAX) ? 7'h00 : cfg.node_id + 7'h01)
                                       : cfg.node_id - 7'h01;
      end
   end

   for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
      // pair drive uses the raw level so the output follows the contact
      assign pair_next[g] = cfg.pair_mode && (nmt_reg == cnc_pkg::CNC_NMT_OPER) && in_reg[g];
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         in_reg <= '0;
         pair_reg <= '0;
         partner_reg <= 7'h00;
      end else begin
         in_reg <= in_next;
         pair_reg <= pair_next;
         partner_reg <= partner_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register port and interrupts
   always_comb begin
      // bus off is a level; only its onset raises an interrupt
      ev = {i_bus_off & ~err_reg.bus_off, i_ev_guard_fail, i_ev_can_error, nmt_next != nmt_reg};
      pol_next = pol_reg;
      imask_next = imask_reg;
      ist_next = ist_reg;
      err_clr_next = 1'b0;
      rdata_next = 32'h0;
      if (i_wr) begin
         case (i_addr)
            cnc_pkg::ADDR_CTRL: err_clr_next = i_wdata[0];
            cnc_pkg::ADDR_IRQ_STAT: ist_next = ist_reg & ~i_wdata[3:0];
            cnc_pkg::ADDR_IRQ_MASK: imask_next = i_wdata[3:0];
            cnc_pkg::ADDR_POLARITY: pol_next = i_wdata[CHANNELS-1:0];
            default: ;
         endcase
      end
      // events merge after the clear, so one landing with a clear is kept
      ist_next = ist_next | ev;
      // unmapped words read as zero and the port never stalls
      if (i_rd) begin
         case (i_addr)
            cnc_pkg::ADDR_STATUS: rdata_next = {8'h0, cfg.rate_kbps, cfg.node_id, cfg.fw_update,
                                                cfg.pair_mode, err_reg, nmt_reg};
            cnc_pkg::ADDR_IRQ_STAT: rdata_next = {28'h0, ist_reg};
            cnc_pkg::ADDR_IRQ_MASK: rdata_next = {28'h0, imask_reg};
            cnc_pkg::ADDR_INPUTS: rdata_next = 32'(in_reg ^ pol_reg);
            cnc_pkg::ADDR_POLARITY: rdata_next = 32'(pol_reg);
            cnc_pkg::ADDR_PAIR: rdata_next = {25'h0, partner_reg};
            default: rdata_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         pol_reg <= '0;
         imask_reg <= 4'h0;
         ist_reg <= 4'h0;
         err_clr_reg <= 1'b0;
         rdata_reg <= 32'h0;
      end else begin
         pol_reg <= pol_next;
         imask_reg <= imask_next;
         ist_reg <= ist_next;
         err_clr_reg <= err_clr_next;
         rdata_reg <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign o_rdata = rdata_reg;
   assign o_irq = |(ist_reg & imask_reg);
   assign o_node_id = cfg.node_id;
   assign o_rate_kbps = cfg.rate_kbps;
   assign o_pair_mode = cfg.pair_mode;
   assign o_fw_update = cfg.fw_update;
   assign o_pair_partner_id = partner_reg;
   assign o_pair_out = pair_reg;
   assign o_input_value = in_reg ^ pol_reg;
   assign o_nmt_state = nmt_reg;
   assign o_term_led = i_term_enable;
   // supply indicator is lit whenever the logic is powered
   assign o_supply_indicator = 1'b1;
   // input leds skip the polarity register on purpose
   assign o_input_led = in_reg;
endmodule

// file: testbench/cnc_tb_fn.svh
// Purpose: expectation helpers shared by checker and bench
// Assumes: switch digits above nine read as nine
// Notes: included inside modules
localparam logic [9:0] KBPS [8] = '{10'h00a, 10'h014, 10'h032, 10'h07d, 10'h0fa, 10'h1f4, 10'h320, 10'h3e8};
function automatic logic [6:0] dig(input logic [3:0] d);
   return (d > 4'h9) ? 7'h09 : {3'h0, d};
endfunction
function automatic logic [6:0] mate(input logic [6:0] id);
   if (id == 7'h00 || id == 7'h63)
      return 7'h00;
   return id[0] ? id + 7'h01 : id - 7'h01;
endfunction

// file: testbench/cnc_node_monitor.sv
// Purpose: port-level assertions for cnc_node
// Assumes: one clock, sync reset i_srst
// Notes: attached by bind after the module
`timescale 1ns/10ps
module cnc_node_chk #(
   parameter int unsigned CHANNELS = 16,
   parameter int unsigned PHASE_CYCLES = 4
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic [3:0] i_sw_tens,
   input wire logic [3:0] i_sw_units,
   input wire logic [3:0] i_sw_rate,
   input wire logic [CHANNELS-1:0] i_sensed_input_channel,
   input wire logic i_term_enable,
   input wire logic i_bus_off,
   input wire logic [6:0] o_node_id,
   input wire logic [9:0] o_rate_kbps,
   input wire logic o_pair_mode,
   input wire logic o_fw_update,
   input wire logic [6:0] o_pair_partner_id,
   input wire logic [CHANNELS-1:0] o_pair_out,
   input wire logic [1:0] o_nmt_state,
   input wire logic o_run_led,
   input wire logic o_err_led,
   input wire logic o_term_led,
   input wire logic [CHANNELS-1:0] o_input_led
);
   `include "cnc_tb_fn.svh"
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
////////////////////////////////////////////////////////////////////////////////
   AST_NODE_ID: assert property (!$past(i_srst) |->
      o_node_id == dig($past(i_sw_tens)) * 7'h0a + dig($past(i_sw_units))) else $error("node id wrong");
   AST_FW_UPD: assert property (!$past(i_srst) |->
      o_fw_update == ($past(i_sw_tens) == 4'h0 && $past(i_sw_units) == 4'h0)) else $error("update mode wrong");
   AST_PAIR_SEL: assert property (!$past(i_srst) |-> o_pair_mode == $past(i_sw_rate[3])) else $error("pair wrong");
   AST_RATE: assert property (!$past(i_srst) |-> o_rate_kbps == KBPS[$past(i_sw_rate[2:0])]) else $error("rate wrong");
   // partner may lag the id by a cycle, so only judged once the id has settled
   AST_MATE: assert property ($stable(o_node_id) ##1 $stable(o_node_id) |->
      o_pair_partner_id == mate(o_node_id)) else $error("partner id wrong");
   AST_PAIR_OUT: assert property (!$past(i_srst) && !$past(i_srst, 2) |-> o_pair_out ==
      (($past(o_nmt_state) == 2'h2 && $past(o_pair_mode)) ? $past(i_sensed_input_channel, 2) : '0))
      else $error("pair out wrong");
   AST_AUTO_OPER: assert property (o_pair_mode && !o_fw_update && o_nmt_state == 2'h1 |->
      ##[1:2] o_nmt_state != 2'h1) else $error("pair mode stayed preop");
   AST_RUN_LIT: assert property ((o_nmt_state == 2'h2) [*2] |=> o_run_led) else $error("run led dark");
   AST_ERR_LIT: assert property (i_bus_off [*3] |=> o_err_led) else $error("error led dark at bus off");
   AST_TERM: assert property (o_term_led == i_term_enable) else $error("terminator led wrong");
   AST_IN_LED: assert property (!$past(i_srst) |->
      o_input_led == $past(i_sensed_input_channel)) else $error("input led wrong");
   cover property (o_pair_mode && o_nmt_state == 2'h2);
   cover property (o_fw_update);
   cover property (i_bus_off && o_err_led);
   cover property ($rose(o_run_led));
endmodule
bind cnc_node cnc_node_chk #(.CHANNELS(CHANNELS), .PHASE_CYCLES(PHASE_CYCLES)) u_chk (.*);

// file: testbench/cnc_pair_out_model.sv
// Purpose: paired 16-channel output module on the far side
// Assumes: own id fixed by the bench
// Notes: no bus timing modelled, one cycle from command to outputs
`timescale 1ns/10ps
module cnc_pair_out_model (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_pair_mode,
   input wire logic [6:0] i_own_id,
   input wire logic [6:0] i_peer_id,
   input wire logic [15:0] i_cmd,
   output logic [15:0] o_out
);
   logic linked;
   logic [15:0] out_next;
   always_comb begin
      linked = i_pair_mode && i_own_id != 7'h00 && (i_own_id[0] ? i_peer_id == i_own_id + 7'h01
         : i_own_id == i_peer_id + 7'h01);
      // operational on its own in pair mode, no start command awaited
      out_next = linked ? i_cmd : 16'h0000;
   end
   always_ff @(posedge i_clk) begin
      o_out <= i_srst ? 16'h0000 : out_next;
   end
endmodule

// file: testbench/tb_top.sv
// Purpose: self-checking bench for cnc_node
// Assumes: PHASE_CYCLES of 4, so one flash window is 40 cycles
// Notes: random values from an lfsr seeded with 78021
`timescale 1ns/10ps
module tb_top;
   `include "cnc_tb_fn.svh"
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic [3:0] i_sw_tens = 4'h0;
   logic [3:0] i_sw_units = 4'h0;
   logic [3:0] i_sw_rate = 4'h0;
   logic [15:0] i_sensed_input_channel = 16'h0000;
   logic i_term_enable = 1'b0;
   logic i_bus_off = 1'b0;
   logic [5:0] cmd = 6'h00;
   wire logic i_nmt_start = cmd[0];
   wire logic i_nmt_stop = cmd[1];
   wire logic i_nmt_preop = cmd[2];
   wire logic i_nmt_reset = cmd[3];
   wire logic i_ev_can_error = cmd[4];
   wire logic i_ev_guard_fail = cmd[5];
   logic [2:0] i_addr = 3'h0;
   logic [31:0] i_wdata = 32'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [31:0] o_rdata;
   logic o_irq, o_pair_mode, o_fw_update, o_run_led, o_err_led, o_term_led, o_supply_indicator;
   logic [6:0] o_node_id, o_pair_partner_id, idx;
   logic [9:0] o_rate_kbps;
   logic [15:0] o_pair_out, o_input_value, o_input_led, peer_out;
   logic [1:0] o_nmt_state;
   logic [31:0] seed = 32'h000130c5;
   logic [31:0] d;
   int num_errors = 0;
   int samples_checked = 0;
   int r, e;
   always #2 i_clk = ~i_clk;
   cnc_node #(.PHASE_CYCLES(4)) dut (.*);
   cnc_pair_out_model peer (.i_clk(i_clk), .i_srst(i_srst), .i_pair_mode(o_pair_mode), .i_own_id(7'h01),
      .i_peer_id(o_node_id), .i_cmd(o_pair_out), .o_out(peer_out));
////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input string w, input logic [31:0] x, input logic [31:0] g);
      samples_checked++;
      if (g !== x) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", w, x, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic wr(input logic [2:0] a, input logic [31:0] v);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= v;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [2:0] a);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic pulse(input int b);
      @(posedge i_clk);
      cmd[b] <= 1'b1;
      @(posedge i_clk);
      cmd <= 6'h00;
      #1;
   endtask
   task automatic do_reset();
      @(posedge i_clk);
      i_srst <= 1'b1;
      repeat (5) @(posedge i_clk);
      i_srst <= 1'b0;
      cyc(3);
   endtask
   // one settle window, then on-cycles of each led over one full pattern window
   task automatic lcnt(input int xr, input int xe);
      cyc(40);
      r = 0;
      e = 0;
      repeat (40) begin
         cyc(1);
         r += (o_run_led === 1'b1);
         e += (o_err_led === 1'b1);
      end
      chk("run led count", xr, r);
      chk("err led count", xe, e);
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
////////////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset();
      for (int k = 0; k < 24; k++) begin
         seed = lfsr(seed);
         @(posedge i_clk);
         i_sw_tens <= (k == 0) ? 4'h0 : (k == 1) ? 4'h9 : (k == 2) ? 4'hc : seed[3:0] % 4'ha;
         i_sw_units <= (k == 0) ? 4'h0 : (k == 1) ? 4'h9 : (k == 2) ? 4'hf : seed[7:4] % 4'ha;
         i_sw_rate <= k[3:0];
         cyc(2);
         idx = dig(i_sw_tens) * 7'h0a + dig(i_sw_units);
         chk("node id", idx, o_node_id);
         chk("update mode", idx == 7'h00, o_fw_update);
         chk("pair mode", i_sw_rate[3], o_pair_mode);
         chk("rate", KBPS[i_sw_rate[2:0]], o_rate_kbps);
         chk("partner", mate(idx), o_pair_partner_id);
         rd(3'h1);
         chk("status id", idx, d[13:7]);
      end
      @(posedge i_clk);
      i_sw_units <= 4'h5;
      i_sw_rate <= 4'h3;
      do_reset();
      chk("state", 2'h1, o_nmt_state);
      lcnt(20, 0);
      pulse(0);
      chk("state", 2'h2, o_nmt_state);
      lcnt(40, 0);
      pulse(2);
      chk("state", 2'h1, o_nmt_state);
      pulse(1);
      lcnt(4, 0);
      pulse(3);
      cyc(2);
      chk("state", 2'h1, o_nmt_state);
      wr(3'h3, 32'hf);
      wr(3'h2, 32'hf);
      chk("irq idle", 1'b0, o_irq);
      pulse(4);
      cyc(1);
      chk("irq", 1'b1, o_irq);
      rd(3'h2);
      chk("irq status", 32'h2, d);
      wr(3'h3, 32'h0);
      chk("irq masked", 1'b0, o_irq);
      wr(3'h3, 32'hf);
      wr(3'h2, 32'h2);
      chk("irq cleared", 1'b0, o_irq);
      lcnt(20, 4);
      pulse(5);
      lcnt(20, 8);
      @(posedge i_clk);
      i_bus_off <= 1'b1;
      lcnt(20, 40);
      @(posedge i_clk);
      i_bus_off <= 1'b0;
      wr(3'h0, 32'h1);
      wr(3'h2, 32'hf);
      lcnt(20, 0);
      wr(3'h7, 32'hffffffff);
      rd(3'h7);
      chk("unmapped", 32'h0, d);
      for (int k = 0; k < 8; k++) begin
         seed = lfsr(seed);
         @(posedge i_clk);
         i_sensed_input_channel <= seed[15:0];
         i_term_enable <= seed[16];
         wr(3'h5, {16'h0, seed[31:16]});
         chk("input led", seed[15:0], o_input_led);
         chk("input value", seed[15:0] ^ seed[31:16], o_input_value);
         chk("terminator", seed[16], o_term_led);
         chk("supply", 1'b1, o_supply_indicator);
         rd(3'h4);
         chk("inputs reg", seed[15:0] ^ seed[31:16], d);
      end
      @(posedge i_clk);
      // id 2 sits just above the model's odd id 1
      i_sw_tens <= 4'h0;
      i_sw_units <= 4'h2;
      i_sw_rate <= 4'hd;
      do_reset();
      chk("pair state", 2'h2, o_nmt_state);
      for (int k = 0; k < 8; k++) begin
         seed = lfsr(seed);
         @(posedge i_clk);
         i_sensed_input_channel <= (k == 0) ? 16'hffff : seed[15:0];
         cyc(3);
         chk("pair out", i_sensed_input_channel, o_pair_out);
         chk("peer out", i_sensed_input_channel, peer_out);
      end
      close_out();
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      num_errors++;
      close_out();
   end
endmodule
